// ---- shared/prs_regs.svh ----
// Constants for the power-on and brown-out reset sequencer
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_CLK_MHZ          200
`define PRS_POR_EXT_US       30
`define PRS_BOR_EXT_US       100
`define PRS_FLAG_POR         0
`define PRS_FLAG_BOR         1
`define PRS_CAUSE_W          2
`define PRS_CAUSE_RST        2'h1
`define PRS_SEL_W            3
`endif

// ---- shared/prs_pkg.sv ----
// Types for the reset sequencer
package prs_pkg;
   // Gray codes along hold, extend, power-up, run
   typedef enum logic [2:0] {
      PRS_HOLD  = 3'h0,
      PRS_EXT   = 3'h1,
      PRS_POWER_UP_TIMER  = 3'h3,
      PRS_RUN   = 3'h2
   } prs_state_e;
   typedef logic [31:0] prs_count_t;
endpackage : prs_pkg

// ---- verilog/prs_delay_timer.sv ----
// Down counter that measures one extension interval
`timescale 1ns/100ps
module prs_delay_timer
   import prs_pkg::*;
#(
   parameter int CW = 32
)(
   // Clock and control
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          ce_i,
   input  wire logic          load_i,
   input  wire logic [CW-1:0] count_i,
   // Status
   output logic               done_o
);
   logic [CW-1:0] remain;
   // Load restarts the interval; done when it reaches zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         remain <= '0;
      else if (ce_i && load_i)
         remain <= count_i;
      else if (ce_i && remain != '0)
         remain <= remain - 1'b1;
   end
   // Done looks at the count only: gating it with load would close a loop
   // through the sequencer, whose load itself depends on done
   assign done_o = (remain == '0);
endmodule : prs_delay_timer

// ---- verilog/prs_sequencer.sv ----
// Power-on / brown-out reset sequencer with power-up timer
`timescale 1ns/100ps
`include "prs_regs.svh"
////////////////////////////////////////////////////////////////////////
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int POR_EXT_CYC = (`PRS_POR_EXT_US * `PRS_CLK_MHZ),
   parameter int BOR_EXT_CYC = (`PRS_BOR_EXT_US * `PRS_CLK_MHZ),
   parameter int MS_CYC      = 1000 * `PRS_CLK_MHZ
)(
   // Clock, power-on reset, enable
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   // Analog monitor indications and external reset
   input  wire logic                    por_ok_i,
   input  wire logic                    bor_ok_i,
   input  wire logic                    ext_rst_i,
   // Configuration
   input  wire logic [`PRS_SEL_W-1:0]   power_up_timer_sel_i,
   // Software access to reset cause
   input  wire logic                    cause_we_i,
   input  wire logic [`PRS_CAUSE_W-1:0] cause_wdata_i,
   // Outputs
   output logic                         system_reset_out_o,
   output logic [`PRS_CAUSE_W-1:0]      cause_o,
   output logic [2:0]                   state_o
);
   ////////////////////////////////////////////////////////////////////
   prs_state_e               state;
   prs_state_e               next_state;
   logic                     bor_seen;
   logic                     bor_prev;
   logic                     load;
   logic [31:0]              load_val;
   logic                     tmr_done;
   logic                     supply_ok;
   logic                     rise;
   logic [`PRS_CAUSE_W-1:0]  cause;

   // All checks run on the one clock and pause while in reset
   default clocking chk_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // power-up delay ladder
   // Power-up delay in ms: 0,2,4,8,16,32,64,128
   function automatic logic [31:0] power_up_timer_cycles(input logic [2:0] sel);
      logic [31:0] ms;
      ms = (sel == 3'h0) ? 32'h0 : (32'h1 << sel);
      return ms * MS_CYC;
   endfunction : power_up_timer_cycles

   ////////////////////////////////////////////////////////////////////
   // inputs decoded combinationally, not registered
   assign supply_ok = por_ok_i && bor_ok_i;
   assign rise      = bor_ok_i && !bor_prev;
   assign load      = (state == PRS_HOLD && supply_ok)
                    || (state == PRS_EXT && tmr_done);
   // brown-out extension once a dip was seen
   assign load_val  = (state == PRS_EXT) ? power_up_timer_cycles(power_up_timer_sel_i)
                    : (bor_seen ? BOR_EXT_CYC : POR_EXT_CYC);

   // Next state: any dip sends us back to hold
   always_comb
   begin
      next_state = state;
      case (state)
         PRS_HOLD: if (supply_ok) next_state = PRS_EXT;
         PRS_EXT:  if (tmr_done)  next_state = PRS_POWER_UP_TIMER;
         PRS_POWER_UP_TIMER: if (tmr_done)  next_state = PRS_RUN;
         PRS_RUN:  next_state = PRS_RUN;
         default:  next_state = PRS_HOLD;
      endcase
      // brown-out or lost supply forces hold
      if (!supply_ok)
         next_state = PRS_HOLD;
   end

   ////////////////////////////////////////////////////////////////////
   // State and edge tracking
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state    <= PRS_HOLD;
         bor_prev <= 1'b0;
         bor_seen <= 1'b0;
      end
      else if (ce_i)
      begin
         state    <= next_state;
         bor_prev <= bor_ok_i;
         if (!bor_ok_i && por_ok_i)
            bor_seen <= 1'b1;
      end
   end

   prs_delay_timer #(.CW(32)) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .load_i  (load),
      .count_i (load_val),
      .done_o  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////
   // Cause flags; hardware set wins over software write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cause <= `PRS_CAUSE_RST;
      else if (ce_i)
      begin
         // software write only, no reset effect
         if (cause_we_i)
            cause <= cause_wdata_i;
         if (!bor_ok_i && por_ok_i)
            cause[`PRS_FLAG_BOR] <= 1'b1;
      end
   end

   assign system_reset_out_o = (state != PRS_RUN) || ext_rst_i;
   assign cause_o            = cause;
   assign state_o            = state;

   ////////////////////////////////////////////////////////////////////
   // Check helpers: cycles with good supply spent in reset, cleared by
   // any dip, so a release can be held against the extension length
   logic [31:0]              chk_hold;
   logic [31:0]              chk_power_up_timer;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || (ce_i && !supply_ok))
         chk_hold <= '0;
      else if (ce_i && state != PRS_RUN)
         chk_hold <= chk_hold + 32'h1;
   end

   // Power-up stage length; still readable on the edge after leaving it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         chk_power_up_timer <= '0;
      else if (ce_i && state == PRS_POWER_UP_TIMER)
         chk_power_up_timer <= chk_power_up_timer + 32'h1;
      else if (ce_i)
         chk_power_up_timer <= '0;
   end

   ////////////////////////////////////////////////////////////////////
   // dip asserts reset
   a_dip_resets: assert property (
      ce_i && !bor_ok_i |=> system_reset_out_o)
      else $error("reset not asserted on brown-out");
   a_bor_flag_set: assert property (
      ce_i && !bor_ok_i && por_ok_i |=> cause[`PRS_FLAG_BOR])
      else $error("brown-out flag not set");
   a_run_needs_ok: assert property (
      state == PRS_RUN && $past(ce_i) |-> $past(supply_ok))
      else $error("released without supply");
   a_ext_reset: assert property (
      ext_rst_i |-> system_reset_out_o)
      else $error("source did not drive reset");
   a_restart_chain: assert property (
      ce_i && rise && por_ok_i && state == PRS_HOLD |=> state == PRS_EXT)
      else $error("delay chain not restarted");
   a_power_up_timer_order: assert property (
      state == PRS_RUN && $past(state) != PRS_RUN
      |-> $past(state) == PRS_POWER_UP_TIMER)
      else $error("run entered without power-up delay");
   a_sw_no_reset: assert property (
      state == PRS_RUN && cause_we_i && supply_ok && !ext_rst_i
      |=> state == PRS_RUN)
      else $error("software write caused reset");
   a_por_cause: assert property (
      $past(rst_i) |-> cause == `PRS_CAUSE_RST)
      else $error("power-on cause wrong");
   a_por_ext_held: assert property (
      state == PRS_RUN && $past(state) == PRS_POWER_UP_TIMER && !bor_seen
      |-> chk_hold > 32'(POR_EXT_CYC))
      else $error("power-on extension cut short");
   a_bor_ext_held: assert property (
      state == PRS_RUN && $past(state) == PRS_POWER_UP_TIMER && bor_seen
      |-> chk_hold > 32'(BOR_EXT_CYC))
      else $error("brown-out extension cut short");
   a_power_up_timer_held: assert property (
      state == PRS_RUN && $past(state) == PRS_POWER_UP_TIMER
      |-> chk_power_up_timer > power_up_timer_cycles(power_up_timer_sel_i))
      else $error("power-up delay cut short");
   a_cause_write: assert property (
      ce_i && cause_we_i && bor_ok_i |=> cause == $past(cause_wdata_i))
      else $error("software write to cause lost");
   a_ce_freeze: assert property (
      !ce_i |=> $stable(state) && $stable(cause))
      else $error("state moved while enable low");
endmodule : prs_sequencer

// ---- tb/prs_supply_model.sv ----
// Supply monitor model: threshold comparators
`timescale 1ns/100ps
module prs_supply_model #(
   parameter int POR_MV = 1800,
   parameter int BOR_MV = 2500
)(
   // Supply level in millivolts
   input  wire logic [11:0] vdd_mv_i,
   // Comparator outputs
   output logic             por_ok_o,
   output logic             bor_ok_o
);
   // No hysteresis, so a dip of any depth is seen
   assign por_ok_o = (int'(vdd_mv_i) >= POR_MV);
   assign bor_ok_o = (int'(vdd_mv_i) >= BOR_MV);
endmodule : prs_supply_model

// ---- tb/power_on_brownout_reset_sequencer_tb.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`include "prs_regs.svh"
module power_on_brownout_reset_sequencer_tb
   import prs_pkg::*;
;
   localparam int POR = 4;
   localparam int BOR = 6;
   localparam int MS  = 10;
   logic        clk_i = 1'b0;
   logic        rst_i, ce_i, ext_rst_i, we, por_ok, bor_ok, sro;
   logic [1:0]  wdata, cause, expc;
   logic [2:0]  sel, state;
   logic [11:0] vdd;
   logic [31:0] seed = 32'hc23a623e;
   int          miscompares = 0;
   int          cmp_count = 0;
   ////////////////////////////////////////////////////////////////////
   // Half period of 2.5 ns
   always #2.5 clk_i = ~clk_i;
   prs_supply_model i_prs_supply_model (.vdd_mv_i(vdd), .por_ok_o(por_ok),
      .bor_ok_o(bor_ok));
   prs_sequencer #(.POR_EXT_CYC(POR), .BOR_EXT_CYC(BOR), .MS_CYC(MS))
   i_prs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .por_ok_i(por_ok), .bor_ok_i(bor_ok), .ext_rst_i(ext_rst_i),
      .power_up_timer_sel_i(sel), .cause_we_i(we), .cause_wdata_i(wdata),
      .system_reset_out_o(sro), .cause_o(cause), .state_o(state));
   ////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Power-of-two ladder of milliseconds
   function int power_up_timer_cyc(input logic [2:0] s);
      return (s == 3'h0) ? 0 : (1 << s) * MS;
   endfunction : power_up_timer_cyc
   task test_done();
      $display("miscompares %0d compares %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task chk_cnt(input int n, input int lo);
      cmp_count++;
      if (n < lo || n > lo + 4)
      begin
         miscompares++;
         $display("Error %0t: released after %0d, min %0d", $time, n, lo);
      end
   endtask : chk_cnt
   // Supply at or above both thresholds, then time the release
   task power_up(input int ext, input logic [2:0] s);
      int n;
      n = 0;
      sel = s;
      vdd = 12'h9c4 + 12'(rnd() & 32'h1ff);
      while (sro !== 1'b0 && n < 2000)
      begin
         @(negedge clk_i);
         n++;
      end
      chk_cnt(n, ext + power_up_timer_cyc(s));
      if (n >= 2000)
         test_done();
   endtask : power_up
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_i, ce_i, ext_rst_i, we, wdata, sel, vdd} = {3'b110, 6'h00, 12'h000};
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      chk(cause, 2'b01);
      // Ramp stays under the power-on level, so no brown-out is recorded
      vdd = 12'h3e8;
      repeat (20) @(negedge clk_i);
      chk({1'b0, sro}, 2'b01);
      power_up(POR, 3'h0);
      expc = 2'b01;
      for (int s = 0; s < 8; s++)
      begin
         vdd = 12'h7d0;
         @(negedge clk_i);
         chk({1'b0, sro}, 2'b01);
         @(negedge clk_i);
         chk(cause, {1'b1, expc[0]});
         // Short recovery, then a second dip restarts the count
         vdd = 12'hbb8;
         repeat (1 + rnd() % 3) @(negedge clk_i);
         vdd = 12'h7d0;
         @(negedge clk_i);
         power_up(BOR, 3'(s));
         expc = 2'(rnd());
         {we, wdata} = {1'b1, expc};
         @(negedge clk_i);
         we = 1'b0;
         @(negedge clk_i);
         chk(cause, expc);
         chk({1'b0, sro}, 2'b00);
      end
      ext_rst_i = 1'b1;
      #1 chk({1'b0, sro}, 2'b01);
      {we, wdata} = 3'b111;
      @(negedge clk_i);
      {we, rst_i} = 2'b01;
      @(negedge clk_i);
      chk(cause, 2'b01);
      test_done();
   end
endmodule : power_on_brownout_reset_sequencer_tb
